// >>> pp_arb_pkg.sv
// Constants and types for the parallel processor RAM port arbiter
// Functional notes
// - The device offers one 4 GB byte-addressed space shared by all processors, each address naming one byte.
// - Addresses below 02000000h decode to on-chip memory, 02000000h to FFFFFFFFh to the off-chip interface.
// - In the two-processor variant only one half of a given RAM can be reached per cycle, so two requests to one RAM conflict.
// - Two requests contending for one RAM in the two-processor variant stall one until the other has completed.
// - In the four-processor variant both halves of a RAM are reached in the same cycle with no contention stall.
// - In the two-processor variant every data RAM of a parallel processor is local to it and served by its local port.
// - An access to RAM that is not local to the requester goes over its global port, whichever port the instruction named.
// - A local-port access to non-local RAM paired with a global-port access stalls the instruction for exactly one cycle.
// - One instruction issues a local-port load and a global-port load together, each post-incrementing its own pointer.
package pp_arb_pkg;

  localparam int ADDR_W = 32;
  localparam int STEP_W = 4;
  localparam int PID_W  = 2;

  // -------------------------------------------------------------------
  // Address decode
  // -------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] ONCHIP_TOP = 32'h0200_0000;
  localparam logic [ADDR_W-1:0] DATA_TOP   = 32'h0001_0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;
  localparam logic [STEP_W-1:0] STEP_RESET = 4'h0;

  // Two-processor variant: 4K data RAMs, bank key [15:12], half bit 11
  localparam int TWO_KEY_LSB = 12;
  localparam int TWO_HALF    = 11;
  localparam int TWO_PAD_MSB = 14;
  localparam int TWO_PAD_LSB = 13;
  localparam int TWO_PID     = 12;

  // Four-processor variant: 2K data RAMs, bank key [15:11]
  localparam int FOUR_KEY_LSB = 11;
  localparam int FOUR_LOC_TOP = 14;
  localparam int FOUR_PID_LSB = 12;

  localparam int KEY_MSB = 15;

  // -------------------------------------------------------------------
  // Instruction sequencer states
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_ISSUE  = 2'b01,
    ST_SECOND = 2'b10
  } state_t;

endpackage

// >>> pp_ram_port_contention.sv
// Port routing and RAM contention arbiter for one parallel processor
`timescale 1ns/1ps
module pp_ram_port_contention #(
  parameter bit                        FOUR_PROC = 1'b0,
  parameter logic [pp_arb_pkg::PID_W-1:0] PROC_ID = 2'h0
) (
  input  wire logic                          mclk,
  input  wire logic                          reset,
  input  wire logic                          ptr_load,
  input  wire logic [pp_arb_pkg::ADDR_W-1:0] ptr_load_la,
  input  wire logic [pp_arb_pkg::ADDR_W-1:0] ptr_load_ga,
  input  wire logic                          instr_valid,
  input  wire logic                          loc_en,
  input  wire logic [pp_arb_pkg::STEP_W-1:0] loc_step,
  input  wire logic                          glb_en,
  input  wire logic [pp_arb_pkg::STEP_W-1:0] glb_step,
  output logic                               stall,
  output logic [pp_arb_pkg::ADDR_W-1:0]      la_ptr,
  output logic [pp_arb_pkg::ADDR_W-1:0]      ga_ptr,
  output logic                               lport_valid,
  output logic [pp_arb_pkg::ADDR_W-1:0]      lport_addr,
  output logic                               gport_valid,
  output logic [pp_arb_pkg::ADDR_W-1:0]      gport_addr,
  output logic                               gport_offchip
);

  // -------------------------------------------------------------------
  // Decode functions
  // -------------------------------------------------------------------
  function automatic logic is_offchip(input logic [31:0] a);
    is_offchip = (a >= pp_arb_pkg::ONCHIP_TOP);
  endfunction

  function automatic logic is_local(input logic [31:0] a);
    logic in_data;
    in_data = (a < pp_arb_pkg::DATA_TOP);
    if (FOUR_PROC) begin
      // Bank at 8000h block is borrowed from another processor
      is_local = (a < (32'h1 << pp_arb_pkg::FOUR_LOC_TOP)) &&
                 (a[pp_arb_pkg::FOUR_PID_LSB +: pp_arb_pkg::PID_W]
                  == PROC_ID);
    end else begin
      is_local = in_data &&
                 (a[pp_arb_pkg::TWO_PAD_MSB:pp_arb_pkg::TWO_PAD_LSB]
                  == 2'h0) &&
                 (a[pp_arb_pkg::TWO_PID] == PROC_ID[0]);
    end
  endfunction

  function automatic logic same_ram(input logic [31:0] a,
                                    input logic [31:0] b);
    logic both;
    both = (a < pp_arb_pkg::DATA_TOP) && (b < pp_arb_pkg::DATA_TOP);
    if (FOUR_PROC)
      same_ram = both &&
        (a[pp_arb_pkg::KEY_MSB:pp_arb_pkg::FOUR_KEY_LSB] ==
         b[pp_arb_pkg::KEY_MSB:pp_arb_pkg::FOUR_KEY_LSB]);
    else
      same_ram = both &&
        (a[pp_arb_pkg::KEY_MSB:pp_arb_pkg::TWO_KEY_LSB] ==
         b[pp_arb_pkg::KEY_MSB:pp_arb_pkg::TWO_KEY_LSB]);
  endfunction

  function automatic logic [31:0] bump(input logic [31:0] p,
                                       input logic [3:0]  s);
    bump = p + {28'h0000000, s};
  endfunction

  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  pp_arb_pkg::state_t state, next_state;
  logic        held_redir,    next_held_redir;
  logic        held_glb,      next_held_glb;
  logic [3:0]  held_lstep,    next_held_lstep;
  logic [3:0]  held_gstep,    next_held_gstep;
  logic        next_stall;
  logic [31:0] next_la_ptr,   next_ga_ptr;
  logic        next_lport_valid, next_gport_valid, next_gport_offchip;
  logic [31:0] next_lport_addr,  next_gport_addr;

  logic accepted;
  logic redir;
  logic clash_port;
  logic clash_ram;
  logic clash;

  // -------------------------------------------------------------------
  // Routing and contention decision
  // -------------------------------------------------------------------
  always_comb begin
    accepted   = instr_valid && (state == pp_arb_pkg::ST_ISSUE);
    redir      = loc_en && !is_local(la_ptr);
    clash_port = redir && glb_en;
    // Half-bank conflict exists only on the two-processor RAMs
    clash_ram  = !FOUR_PROC && loc_en && !redir && glb_en &&
                 same_ram(la_ptr, ga_ptr);
    clash      = accepted && (clash_port || clash_ram);
  end

  always_comb begin
    next_state         = state;
    next_held_redir    = held_redir;
    next_held_glb      = held_glb;
    next_held_lstep    = held_lstep;
    next_held_gstep    = held_gstep;
    next_stall         = 1'b0;
    next_la_ptr        = la_ptr;
    next_ga_ptr        = ga_ptr;
    next_lport_valid   = 1'b0;
    next_lport_addr    = lport_addr;
    next_gport_valid   = 1'b0;
    next_gport_addr    = gport_addr;
    next_gport_offchip = gport_offchip;
    unique case (state)
      pp_arb_pkg::ST_ISSUE: begin
        if (clash) begin
          // Global-port access goes first, local one waits a cycle
          next_gport_valid   = 1'b1;
          next_gport_addr    = ga_ptr;
          next_gport_offchip = is_offchip(ga_ptr);
          next_held_redir    = redir;
          next_held_glb      = glb_en;
          next_held_lstep    = loc_step;
          next_held_gstep    = glb_step;
          next_stall         = 1'b1;
          next_state         = pp_arb_pkg::ST_SECOND;
        end else if (accepted) begin
          if (loc_en && !redir) begin
            next_lport_valid = 1'b1;
            next_lport_addr  = la_ptr;
          end
          if (redir) begin
            next_gport_valid   = 1'b1;
            next_gport_addr    = la_ptr;
            next_gport_offchip = is_offchip(la_ptr);
          end
          if (glb_en) begin
            next_gport_valid   = 1'b1;
            next_gport_addr    = ga_ptr;
            next_gport_offchip = is_offchip(ga_ptr);
            next_ga_ptr        = bump(ga_ptr, glb_step);
          end
          if (loc_en)
            next_la_ptr = bump(la_ptr, loc_step);
        end else if (ptr_load) begin
          next_la_ptr = ptr_load_la;
          next_ga_ptr = ptr_load_ga;
        end
      end
      pp_arb_pkg::ST_SECOND: begin
        // Held access completes; pointers move only now
        if (held_redir) begin
          next_gport_valid   = 1'b1;
          next_gport_addr    = la_ptr;
          next_gport_offchip = is_offchip(la_ptr);
        end else begin
          next_lport_valid = 1'b1;
          next_lport_addr  = la_ptr;
        end
        next_la_ptr = bump(la_ptr, held_lstep);
        if (held_glb)
          next_ga_ptr = bump(ga_ptr, held_gstep);
        next_state = pp_arb_pkg::ST_ISSUE;
      end
      default: next_state = pp_arb_pkg::ST_ISSUE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state         <= pp_arb_pkg::ST_ISSUE;
      held_redir    <= 1'b0;
      held_glb      <= 1'b0;
      held_lstep    <= pp_arb_pkg::STEP_RESET;
      held_gstep    <= pp_arb_pkg::STEP_RESET;
      stall         <= 1'b0;
      la_ptr        <= pp_arb_pkg::ADDR_RESET;
      ga_ptr        <= pp_arb_pkg::ADDR_RESET;
      lport_valid   <= 1'b0;
      lport_addr    <= pp_arb_pkg::ADDR_RESET;
      gport_valid   <= 1'b0;
      gport_addr    <= pp_arb_pkg::ADDR_RESET;
      gport_offchip <= 1'b0;
    end else begin
      state         <= next_state;
      held_redir    <= next_held_redir;
      held_glb      <= next_held_glb;
      held_lstep    <= next_held_lstep;
      held_gstep    <= next_held_gstep;
      stall         <= next_stall;
      la_ptr        <= next_la_ptr;
      ga_ptr        <= next_ga_ptr;
      lport_valid   <= next_lport_valid;
      lport_addr    <= next_lport_addr;
      gport_valid   <= next_gport_valid;
      gport_addr    <= next_gport_addr;
      gport_offchip <= next_gport_offchip;
    end
  end

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  AST_STALL_ONE_CYCLE: assert property (
    clash |=> stall ##1 !stall)
    else $error("stall did not last exactly one cycle");

  AST_STALL_SEQUENCE: assert property (
    clash |=> gport_valid && gport_addr == $past(ga_ptr)
          ##1 (lport_valid || gport_valid) && !stall)
    else $error("held access did not follow the global one");

  AST_REDIRECT: assert property (
    accepted && redir && !glb_en |=>
      gport_valid && !lport_valid && gport_addr == $past(la_ptr))
    else $error("non-local access not sent over global port");

  AST_OFFCHIP_DECODE: assert property (
    gport_valid |-> gport_offchip == (gport_addr >= pp_arb_pkg::ONCHIP_TOP))
    else $error("off-chip decode wrong");

  AST_LOCAL_ONLY: assert property (
    lport_valid |-> is_local(lport_addr))
    else $error("local port carried non-local address");

  AST_FOUR_NO_HALF_STALL: assert property (
    FOUR_PROC && accepted && !clash_port |=> !stall)
    else $error("four-processor variant stalled on one RAM");

  AST_ONE_RAM_PER_CYCLE: assert property (
    !FOUR_PROC && lport_valid && gport_valid |->
      !same_ram(lport_addr, gport_addr))
    else $error("two accesses reached one RAM in a cycle");

  AST_HOLD_WHILE_STALLED: assert property (
    stall |-> $stable(la_ptr) && $stable(ga_ptr))
    else $error("pointer moved during stall");

  AST_POSTINC: assert property (
    accepted && !clash && glb_en && loc_en |=>
      ga_ptr == $past(ga_ptr) + 32'($past(glb_step)) &&
      la_ptr == $past(la_ptr) + 32'($past(loc_step)))
    else $error("post-increment wrong");

  COV_PARALLEL: cover property (accepted && loc_en && glb_en && !clash);
  COV_PORT_CLASH: cover property (accepted && clash_port);
  COV_RAM_CLASH: cover property (accepted && clash_ram);
  COV_REDIRECT: cover property (accepted && redir && !glb_en);

endmodule // pp_ram_port_contention

// >>> pp_requester.sv
// Behavioural address unit that issues one instruction at a time
`timescale 1ns/1ps
module pp_requester (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       go,
  input  wire logic       go_loc,
  input  wire logic       go_glb,
  input  wire logic [3:0] go_ls,
  input  wire logic [3:0] go_gs,
  input  wire logic       stall,
  output logic            instr_valid,
  output logic            loc_en,
  output logic            glb_en,
  output logic [3:0]      loc_step,
  output logic [3:0]      glb_step
);
  // Request held until an edge without stall takes it
  always_ff @(posedge mclk) begin
    if (reset) begin
      instr_valid <= 1'h0;
      loc_en <= 1'h0;
      glb_en <= 1'h0;
      loc_step <= 4'h0;
      glb_step <= 4'h0;
    end else if (go) begin
      instr_valid <= 1'h1;
      loc_en <= go_loc;
      glb_en <= go_glb;
      loc_step <= go_ls;
      glb_step <= go_gs;
    end else if (instr_valid && !stall) begin
      instr_valid <= 1'h0;
      loc_en <= 1'h0;
      glb_en <= 1'h0;
      loc_step <= ~loc_step;
      glb_step <= ~glb_step;
    end
  end
endmodule // pp_requester

// >>> pp_ram_port_contention_tb.sv
// Self-checking bench for the RAM port contention arbiter
`timescale 1ns/1ps
module pp_ram_port_contention_tb;
  logic        mclk, reset, ptr_load, go, go_loc, go_glb;
  logic [31:0] ld_la, ld_ga, la_ptr, ga_ptr, laddr, gaddr;
  logic [3:0]  go_ls, go_gs, ls, gs;
  logic        iv, le, ge, stall, lv, gv, off, stall4, lv4, gv4;
  int          n_mismatch = 0;
  int          tests_run = 0;

  pp_requester req (.mclk(mclk), .reset(reset), .go(go), .go_loc(go_loc),
    .go_glb(go_glb), .go_ls(go_ls), .go_gs(go_gs), .stall(stall),
    .instr_valid(iv), .loc_en(le), .glb_en(ge), .loc_step(ls),
    .glb_step(gs));
  pp_ram_port_contention #(.FOUR_PROC(1'h0), .PROC_ID(2'h0)) uut (
    .mclk(mclk), .reset(reset), .ptr_load(ptr_load),
    .ptr_load_la(ld_la), .ptr_load_ga(ld_ga), .instr_valid(iv),
    .loc_en(le), .loc_step(ls), .glb_en(ge), .glb_step(gs), .stall(stall),
    .la_ptr(la_ptr), .ga_ptr(ga_ptr), .lport_valid(lv),
    .lport_addr(laddr), .gport_valid(gv), .gport_addr(gaddr),
    .gport_offchip(off));
  pp_ram_port_contention #(.FOUR_PROC(1'h1), .PROC_ID(2'h0)) uut_four (
    .mclk(mclk), .reset(reset), .ptr_load(ptr_load),
    .ptr_load_la(ld_la), .ptr_load_ga(ld_ga), .instr_valid(iv),
    .loc_en(le), .loc_step(ls), .glb_en(ge), .glb_step(gs),
    .stall(stall4), .la_ptr(), .ga_ptr(), .lport_valid(lv4),
    .lport_addr(), .gport_valid(gv4), .gport_addr(), .gport_offchip());

  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask
  task automatic see(input logic s, v, input logic [31:0] a,
                     input logic w, input logic [31:0] b);
    chk(32'(stall), 32'(s));
    chk(32'(lv), 32'(v));
    chk(32'(gv), 32'(w));
    if (v) chk(laddr, a);
    if (w) chk(gaddr, b);
  endtask
  task automatic nxt();
    @(posedge mclk);
    #1;
  endtask
  task automatic load(input logic [31:0] a, b);
    @(posedge mclk);
    ptr_load <= 1'h1;
    ld_la <= a;
    ld_ga <= b;
    @(posedge mclk);
    ptr_load <= 1'h0;
  endtask
  // Ends 1 ns after the edge at which the arbiter takes the instruction
  task automatic issue(input logic l, g, input logic [3:0] a, b);
    @(posedge mclk);
    go <= 1'h1;
    go_loc <= l;
    go_glb <= g;
    go_ls <= a;
    go_gs <= b;
    @(posedge mclk);
    go <= 1'h0;
    nxt();
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic s_dual();
    load(32'h100, 32'h8000);
    issue(1'h1, 1'h1, 4'h2, 4'h4);
    see(1'h0, 1'h1, 32'h100, 1'h1, 32'h8000);
    chk(la_ptr, 32'h102);
    chk(ga_ptr, 32'h8004);
    issue(1'h1, 1'h1, 4'h1, 4'hF);
    see(1'h0, 1'h1, 32'h102, 1'h1, 32'h8004);
    chk(la_ptr, 32'h103);
    nxt();
    see(1'h0, 1'h0, 32'h0, 1'h0, 32'h0);
  endtask
  task automatic s_same();
    load(32'h200, 32'h800);
    issue(1'h1, 1'h1, 4'h2, 4'h2);
    see(1'h1, 1'h0, 32'h0, 1'h1, 32'h800);
    chk(la_ptr, 32'h200);
    chk(32'({stall4, lv4, gv4}), 32'h3);
    nxt();
    see(1'h0, 1'h1, 32'h200, 1'h0, 32'h0);
    chk(ga_ptr, 32'h802);
  endtask
  task automatic s_redir();
    load(32'h1000, 32'h200_0000);
    issue(1'h1, 1'h1, 4'h4, 4'h8);
    see(1'h1, 1'h0, 32'h0, 1'h1, 32'h200_0000);
    chk(32'(off), 32'h1);
    chk(32'(stall4), 32'h1);
    nxt();
    see(1'h0, 1'h0, 32'h0, 1'h1, 32'h1000);
    chk(32'(off), 32'h0);
    chk(la_ptr, 32'h1004);
    load(32'h1000, 32'h0);
    issue(1'h1, 1'h0, 4'h1, 4'h0);
    see(1'h0, 1'h0, 32'h0, 1'h1, 32'h1000);
  endtask
  task automatic s_offchip();
    logic [31:0] a[3];
    a = '{32'h1FF_FFFF, 32'h200_0000, 32'hFFFF_FFFF};
    for (int i = 0; i < 3; i++) begin
      load(32'h0, a[i]);
      issue(1'h0, 1'h1, 4'h0, 4'h1);
      see(1'h0, 1'h0, 32'h0, 1'h1, a[i]);
      chk(32'(off), {31'h0, i > 0});
      chk(ga_ptr, a[i] + 32'h1);
    end
  endtask
  // Reset lands while the held access of a conflict is pending
  task automatic s_reset();
    load(32'h200, 32'h800);
    @(posedge mclk);
    go <= 1'h1;
    go_loc <= 1'h1;
    go_glb <= 1'h1;
    go_ls <= 4'h2;
    go_gs <= 4'h2;
    @(posedge mclk);
    go <= 1'h0;
    @(posedge mclk);
    reset <= 1'h1;
    #1;
    chk(32'(stall), 32'h1);
    repeat (2) @(posedge mclk);
    reset <= 1'h0;
    nxt();
    see(1'h0, 1'h0, 32'h0, 1'h0, 32'h0);
    chk(la_ptr, 32'h0);
    chk(ga_ptr, 32'h0);
    issue(1'h0, 1'h1, 4'h0, 4'h1);
    see(1'h0, 1'h0, 32'h0, 1'h1, 32'h0);
    chk(32'(off), 32'h0);
    chk(ga_ptr, 32'h1);
  endtask

  initial begin
    reset = 1'h1;
    ptr_load = 1'h0;
    go = 1'h0;
    {go_loc, go_glb, go_ls, go_gs, ld_la, ld_ga} = '0;
    repeat (2) @(posedge mclk);
    reset <= 1'h0;
    nxt();
    see(1'h0, 1'h0, 32'h0, 1'h0, 32'h0);
    chk(la_ptr, 32'h0);
    chk(ga_ptr, 32'h0);
    chk(laddr, 32'h0);
    chk(gaddr, 32'h0);
    chk(32'(off), 32'h0);
    s_dual();
    s_same();
    s_redir();
    s_offchip();
    s_reset();
    test_done();
  end

  initial begin
    #50000;
    n_mismatch++;
    test_done();
  end
endmodule // pp_ram_port_contention_tb
